/* File: include/cfl_pkg.sv */
// Purpose: shared constants and types for the core status flag block
// Assumes: 8-bit core, one core clock, sequencer issues one operation per cycle
// Notes: register offsets index the plain register port, one byte per offset
package cfl_pkg;

  // flag bit positions inside the flag byte
  localparam int unsigned BIT_CARRY = 0;
  localparam int unsigned BIT_ZERO = 1;
  localparam int unsigned BIT_MASK = 2;
  localparam int unsigned BIT_BCD = 3;
  localparam int unsigned BIT_TRAP = 4;
  localparam int unsigned BIT_PAIR = 5;
  localparam int unsigned BIT_RANGE = 6;
  localparam int unsigned BIT_SIGN = 7;

  // flag byte value after reset, interrupts masked
  localparam logic [7:0] FLAG_RST = 8'h04;
  // bits that exist as flip-flops in the live byte (trap bit always 0)
  localparam logic [7:0] FLAG_LIVE_MASK = 8'hEF;

  // register port map
  localparam int unsigned REG_AW = 4;
  localparam logic [REG_AW-1:0] OFS_FLAG = 4'h0;
  localparam logic [REG_AW-1:0] OFS_RESULT = 4'h1;
  localparam logic [REG_AW-1:0] OFS_STACKED = 4'h2;
  localparam logic [REG_AW-1:0] OFS_STATE = 4'h3;
  // fields of the read-only state register
  localparam int unsigned ST_VALID = 0;
  localparam int unsigned ST_BCD = 1;
  localparam int unsigned ST_PAIR = 2;
  localparam int unsigned ST_MASK = 3;

  // reset release depth
  localparam int unsigned RST_SYNC_DEPTH = 2;

  // decimal correction constants
  localparam logic [4:0] BCD_MAX_DIGIT = 5'h09;
  localparam logic [4:0] BCD_ADJUST = 5'h06;

  // operations issued by the instruction sequencer
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_ADD_CARRY = 5'h01,
    OP_SUB_BORROW = 5'h02,
    OP_TRANSFER = 5'h03,
    OP_SHIFT_LEFT = 5'h04,
    OP_SHIFT_RIGHT = 5'h05,
    OP_ROTATE_LEFT = 5'h06,
    OP_ROTATE_RIGHT = 5'h07,
    OP_BIT_TEST = 5'h08,
    OP_SET_CARRY = 5'h09,
    OP_CLEAR_CARRY = 5'h0A,
    OP_MASK_IRQ = 5'h0B,
    OP_UNMASK_IRQ = 5'h0C,
    OP_ENTER_BCD = 5'h0D,
    OP_LEAVE_BCD = 5'h0E,
    OP_ENABLE_PAIR = 5'h0F,
    OP_DISABLE_PAIR = 5'h10,
    OP_CLEAR_RANGE = 5'h11,
    OP_PUSH_FLAGS = 5'h12,
    OP_PULL_FLAGS = 5'h13,
    OP_SOFT_TRAP = 5'h14,
    OP_IRQ_ENTRY = 5'h15
  } cfl_op_t;

  // flags a conditional branch can test
  typedef enum logic [1:0] {
    COND_CARRY = 2'h0,
    COND_ZERO = 2'h1,
    COND_RANGE = 2'h2,
    COND_SIGN = 2'h3
  } cfl_cond_sel_t;

  // one operation request from the sequencer
  typedef struct packed {
    cfl_op_t op;
    logic [7:0] acc; // accumulator or first operand
    logic [7:0] mem; // memory operand or pulled flag byte
  } cfl_op_req_t;

  // one branch test request
  typedef struct packed {
    cfl_cond_sel_t sel;
    logic want; // flag value that takes the branch
  } cfl_branch_t;

endpackage

/* File: logic/cfl_arith.sv */
// Purpose: 8-bit add with carry and subtract with borrow, binary or decimal
// Assumes: carry input follows the no-borrow convention for subtraction
// Notes: overflow is the binary figure even in decimal mode
module cfl_arith (
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic carry_in,
  input wire logic sub_in,
  input wire logic bcd_in,
  output logic [7:0] sum_out,
  output logic carry_out,
  output logic range_out
);

  logic [7:0] b_eff;
  logic [8:0] bin_sum;
  logic [4:0] lo;
  logic [4:0] hi;
  logic lo_c;

  // binary path, subtraction adds the inverted operand
  assign b_eff = sub_in ? ~b_in : b_in;
  assign bin_sum = {1'b0, a_in} + {1'b0, b_eff} + {8'h00, carry_in};

  // decimal correction per nibble
  always_comb begin
    lo = 5'h00;
    hi = 5'h00;
    lo_c = 1'b0;
    sum_out = bin_sum[7:0];
    carry_out = bin_sum[8];
    if (bcd_in && !sub_in) begin
      lo = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};
      lo_c = (lo > cfl_pkg::BCD_MAX_DIGIT);
      if (lo_c) begin
        lo = lo + cfl_pkg::BCD_ADJUST;
      end
      hi = {1'b0, a_in[7:4]} + {1'b0, b_in[7:4]} + {4'h0, lo_c};
      carry_out = (hi > cfl_pkg::BCD_MAX_DIGIT);
      if (carry_out) begin
        hi = hi + cfl_pkg::BCD_ADJUST;
      end
      sum_out = {hi[3:0], lo[3:0]};
    end else if (bcd_in) begin
      lo = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, ~carry_in};
      lo_c = lo[4]; // nibble borrow
      if (lo_c) begin
        lo = lo - cfl_pkg::BCD_ADJUST;
      end
      hi = {1'b0, a_in[7:4]} - {1'b0, b_in[7:4]} - {4'h0, lo_c};
      carry_out = ~hi[4];
      if (hi[4]) begin
        hi = hi - cfl_pkg::BCD_ADJUST;
      end
      sum_out = {hi[3:0], lo[3:0]};
    end
  end

  // signed result left the range +127 .. -128
  assign range_out = (a_in[7] == b_eff[7]) && (bin_sum[7] != a_in[7]);

endmodule

/* File: logic/cfl_status_flags.sv */
// Purpose: processor flag byte of the 8-bit core with its result and mode flags
// Assumes: sequencer drives one request per cycle; register port has no wait states
// Notes: a sequencer update and a software write in one cycle, the sequencer wins on the bits its op sets; result ops and pull drop the write
//   zero, overflow and negative still update in decimal mode, flagged not valid
//   the trap bit is never a flip-flop in the live byte, only in stacked copies
//
// Contract
// - Eight-bit flag byte: four result flags, three operating-mode flags, one trap bit.
// - Branches can test carry, zero, overflow or negative flag.
// - Zero, overflow and negative are marked not valid in decimal mode.
// - Carry takes arithmetic carry or borrow; shifts and rotates update it.
// - Zero flag set on zero arithmetic or transfer result, else cleared.
// - Mask flag at 1 blocks all interrupts except the software trap.
// - Decimal flag selects decimal arithmetic with automatic correction.
// - Only add-with-carry and subtract-with-borrow use decimal mode.
// - Trap bit reads 0 live; stacked byte of a trap carries 1.
// - Pair flag selects accumulator-memory or memory-memory operation.
// - Overflow set when signed byte add or subtract leaves +127..-128.
// - Bit test copies memory bit 6 into the overflow flag.
// - Negative flag set on negative arithmetic or transfer result.
// - Bit test copies memory bit 7 into the negative flag.
// - Set and clear ops for carry, mask, decimal, pair; clear-only overflow.
module cfl_status_flags (
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic OP_VALID_IN,
  input wire cfl_pkg::cfl_op_req_t OP_REQ_IN,
  input wire cfl_pkg::cfl_branch_t BRANCH_IN,
  input wire logic IRQ_PEND_IN,
  input wire logic [cfl_pkg::REG_AW-1:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic [7:0] FLAGS_OUT,
  output logic [7:0] RESULT_OUT,
  output logic [7:0] STACKED_OUT,
  output logic BRANCH_TAKEN_OUT,
  output logic IRQ_ACCEPT_OUT,
  output logic BCD_MODE_OUT,
  output logic PAIR_MODE_OUT,
  output logic FLAGS_VALID_OUT
);

  // reset release chain, asserted at once, released after two edges
  logic [cfl_pkg::RST_SYNC_DEPTH-1:0] rst_sync_reg;
  logic [cfl_pkg::RST_SYNC_DEPTH-1:0] rst_sync_next;
  logic rstn;

  // shift a one in at the bottom, only the top flop is read outside the chain
  always_comb begin
    rst_sync_next = {rst_sync_reg[cfl_pkg::RST_SYNC_DEPTH-2:0], 1'b1};
  end

  // chain flops clear at once so the core never runs on a half-released reset
  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_sync_reg <= '0;
    end else begin
      rst_sync_reg <= rst_sync_next;
    end
  end

  assign rstn = rst_sync_reg[cfl_pkg::RST_SYNC_DEPTH-1];

  // live flag byte with trap bit forced low
  function automatic logic [7:0] live_byte(input logic [7:0] v);
    live_byte = v & cfl_pkg::FLAG_LIVE_MASK;
  endfunction

  // zero and negative from an 8-bit result
  function automatic logic [7:0] zn_update(input logic [7:0] f, input logic [7:0] r);
    logic [7:0] t;
    t = f;
    t[cfl_pkg::BIT_ZERO] = (r == 8'h00);
    t[cfl_pkg::BIT_SIGN] = r[7];
    zn_update = t;
  endfunction

  // shifted or rotated accumulator; rotates pull the old carry into the free end
  function automatic logic [7:0] shift_res(input cfl_pkg::cfl_op_t op, input logic [7:0] v,
                                           input logic c);
    logic [7:0] t;
    t = v;
    case (op)
      cfl_pkg::OP_SHIFT_LEFT: begin
        t = {v[6:0], 1'b0};
      end
      cfl_pkg::OP_SHIFT_RIGHT: begin
        t = {1'b0, v[7:1]};
      end
      cfl_pkg::OP_ROTATE_LEFT: begin
        t = {v[6:0], c};
      end
      cfl_pkg::OP_ROTATE_RIGHT: begin
        t = {c, v[7:1]};
      end
      default: begin
        t = v;
      end
    endcase
    shift_res = t;
  endfunction

  // bit that leaves the byte on a shift or rotate, taken into carry
  function automatic logic shift_out(input cfl_pkg::cfl_op_t op, input logic [7:0] v);
    logic b;
    b = v[0];
    if ((op == cfl_pkg::OP_SHIFT_LEFT) || (op == cfl_pkg::OP_ROTATE_LEFT)) begin
      b = v[7];
    end
    shift_out = b;
  endfunction

  // read-only state byte: validity and the three mode flags
  function automatic logic [7:0] state_byte(input logic [7:0] f);
    logic [7:0] t;
    t = 8'h00;
    t[cfl_pkg::ST_VALID] = ~f[cfl_pkg::BIT_BCD];
    t[cfl_pkg::ST_BCD] = f[cfl_pkg::BIT_BCD];
    t[cfl_pkg::ST_PAIR] = f[cfl_pkg::BIT_PAIR];
    t[cfl_pkg::ST_MASK] = f[cfl_pkg::BIT_MASK];
    state_byte = t;
  endfunction

  // registered flag byte, result, stacked copy and read data with next values
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic [7:0] stacked_reg;
  logic [7:0] stacked_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // adder and shifter taps
  logic is_arith;
  logic [7:0] ar_sum;
  logic ar_carry;
  logic ar_range;
  logic [7:0] sh_res;
  logic sh_carry;

  // decimal applies only to the two carry-chain arithmetic ops
  assign is_arith = OP_VALID_IN && ((OP_REQ_IN.op == cfl_pkg::OP_ADD_CARRY) ||
                                    (OP_REQ_IN.op == cfl_pkg::OP_SUB_BORROW));

  // shift and rotate result and outgoing bit, shared by the four shift ops
  assign sh_res = shift_res(OP_REQ_IN.op, OP_REQ_IN.acc, flag_reg[cfl_pkg::BIT_CARRY]);
  assign sh_carry = shift_out(OP_REQ_IN.op, OP_REQ_IN.acc);

  // adder with decimal correction
  cfl_arith u_arith (
    .a_in(OP_REQ_IN.acc),
    .b_in(OP_REQ_IN.mem),
    .carry_in(flag_reg[cfl_pkg::BIT_CARRY]),
    .sub_in(OP_REQ_IN.op == cfl_pkg::OP_SUB_BORROW),
    .bcd_in(is_arith && flag_reg[cfl_pkg::BIT_BCD]),
    .sum_out(ar_sum),
    .carry_out(ar_carry),
    .range_out(ar_range)
  );

  // next flag byte, result and stacked copy
  always_comb begin
    flag_next = flag_reg;
    result_next = result_reg;
    stacked_next = stacked_reg;
    // software write; result ops and pull override it in the same cycle, other ops only on the bits they set
    if (REG_WR_IN && (REG_ADDR_IN == cfl_pkg::OFS_FLAG)) begin
      flag_next = live_byte(REG_WDATA_IN);
    end
    if (OP_VALID_IN) begin
      case (OP_REQ_IN.op)
        cfl_pkg::OP_ADD_CARRY, cfl_pkg::OP_SUB_BORROW: begin
          result_next = ar_sum;
          flag_next = zn_update(flag_reg, ar_sum);
          flag_next[cfl_pkg::BIT_CARRY] = ar_carry;
          flag_next[cfl_pkg::BIT_RANGE] = ar_range;
        end
        cfl_pkg::OP_TRANSFER: begin
          result_next = OP_REQ_IN.mem;
          flag_next = zn_update(flag_reg, OP_REQ_IN.mem);
        end
        cfl_pkg::OP_SHIFT_LEFT, cfl_pkg::OP_SHIFT_RIGHT,
        cfl_pkg::OP_ROTATE_LEFT, cfl_pkg::OP_ROTATE_RIGHT: begin
          result_next = sh_res;
          flag_next = zn_update(flag_reg, sh_res);
          flag_next[cfl_pkg::BIT_CARRY] = sh_carry;
        end
        cfl_pkg::OP_BIT_TEST: begin
          // zero reflects the masked pair, sign and range copy the memory byte
          flag_next[cfl_pkg::BIT_ZERO] = ((OP_REQ_IN.acc & OP_REQ_IN.mem) == 8'h00);
          flag_next[cfl_pkg::BIT_RANGE] = OP_REQ_IN.mem[6];
          flag_next[cfl_pkg::BIT_SIGN] = OP_REQ_IN.mem[7];
        end
        // dedicated set and clear ops; zero, trap and sign have none
        cfl_pkg::OP_SET_CARRY: begin
          flag_next[cfl_pkg::BIT_CARRY] = 1'b1;
        end
        cfl_pkg::OP_CLEAR_CARRY: begin
          flag_next[cfl_pkg::BIT_CARRY] = 1'b0;
        end
        cfl_pkg::OP_MASK_IRQ: begin
          flag_next[cfl_pkg::BIT_MASK] = 1'b1;
        end
        cfl_pkg::OP_UNMASK_IRQ: begin
          flag_next[cfl_pkg::BIT_MASK] = 1'b0;
        end
        cfl_pkg::OP_ENTER_BCD: begin
          flag_next[cfl_pkg::BIT_BCD] = 1'b1;
        end
        cfl_pkg::OP_LEAVE_BCD: begin
          flag_next[cfl_pkg::BIT_BCD] = 1'b0;
        end
        cfl_pkg::OP_ENABLE_PAIR: begin
          flag_next[cfl_pkg::BIT_PAIR] = 1'b1;
        end
        cfl_pkg::OP_DISABLE_PAIR: begin
          flag_next[cfl_pkg::BIT_PAIR] = 1'b0;
        end
        cfl_pkg::OP_CLEAR_RANGE: begin
          flag_next[cfl_pkg::BIT_RANGE] = 1'b0;
        end
        cfl_pkg::OP_PUSH_FLAGS: begin
          stacked_next = live_byte(flag_reg);
        end
        cfl_pkg::OP_PULL_FLAGS: begin
          flag_next = live_byte(OP_REQ_IN.mem);
        end
        cfl_pkg::OP_SOFT_TRAP: begin
          // stacked copy marks the trap; entry masks further interrupts
          stacked_next = live_byte(flag_reg) | (8'h01 << cfl_pkg::BIT_TRAP);
          flag_next[cfl_pkg::BIT_MASK] = 1'b1;
        end
        cfl_pkg::OP_IRQ_ENTRY: begin
          stacked_next = live_byte(flag_reg);
          flag_next[cfl_pkg::BIT_MASK] = 1'b1;
        end
        default: begin
          stacked_next = stacked_reg; // unknown codes change nothing
        end
      endcase
    end
  end

  // flag byte, result and stacked copy registers
  always_ff @(posedge CORE_CLK_IN or negedge rstn) begin
    if (!rstn) begin
      flag_reg <= cfl_pkg::FLAG_RST;
      result_reg <= 8'h00;
      stacked_reg <= 8'h00;
    end else begin
      flag_reg <= flag_next;
      result_reg <= result_next;
      stacked_reg <= stacked_next;
    end
  end

  // register read mux, answer stands in the following cycle only
  always_comb begin
    rdata_next = 8'h00;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        cfl_pkg::OFS_FLAG: rdata_next = live_byte(flag_reg);
        cfl_pkg::OFS_RESULT: rdata_next = result_reg;
        cfl_pkg::OFS_STACKED: rdata_next = stacked_reg;
        cfl_pkg::OFS_STATE: rdata_next = state_byte(flag_reg);
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge CORE_CLK_IN or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // flag picked by the branch selector
  logic branch_flag;

  // branch test on one of the four result flags
  always_comb begin
    case (BRANCH_IN.sel)
      cfl_pkg::COND_CARRY: branch_flag = flag_reg[cfl_pkg::BIT_CARRY];
      cfl_pkg::COND_ZERO: branch_flag = flag_reg[cfl_pkg::BIT_ZERO];
      cfl_pkg::COND_RANGE: branch_flag = flag_reg[cfl_pkg::BIT_RANGE];
      cfl_pkg::COND_SIGN: branch_flag = flag_reg[cfl_pkg::BIT_SIGN];
      default: branch_flag = 1'b0;
    endcase
  end

  // handshake outputs, combinational from the live flags
  assign BRANCH_TAKEN_OUT = (branch_flag == BRANCH_IN.want);
  assign IRQ_ACCEPT_OUT = IRQ_PEND_IN && !flag_reg[cfl_pkg::BIT_MASK];

  // data outputs straight from flip-flops
  assign REG_RDATA_OUT = rdata_reg;
  assign FLAGS_OUT = flag_reg;
  assign RESULT_OUT = result_reg;
  assign STACKED_OUT = stacked_reg;
  assign BCD_MODE_OUT = flag_reg[cfl_pkg::BIT_BCD];
  assign PAIR_MODE_OUT = flag_reg[cfl_pkg::BIT_PAIR];
  assign FLAGS_VALID_OUT = ~flag_reg[cfl_pkg::BIT_BCD];

endmodule

/* File: verification/cfl_status_flags_asserts.sv */
// Purpose: port-level checks on the core status flag block
// Assumes: one clock domain, no op is issued while reset is active
// Notes: bound to the flag block from the bench top file
module cfl_flags_asserts (
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic OP_VALID_IN,
  input wire cfl_pkg::cfl_op_req_t OP_REQ_IN,
  input wire cfl_pkg::cfl_branch_t BRANCH_IN,
  input wire logic IRQ_PEND_IN,
  input wire logic [7:0] FLAGS_OUT,
  input wire logic [7:0] RESULT_OUT,
  input wire logic [7:0] STACKED_OUT,
  input wire logic BRANCH_TAKEN_OUT,
  input wire logic IRQ_ACCEPT_OUT,
  input wire logic BCD_MODE_OUT,
  input wire logic PAIR_MODE_OUT,
  input wire logic FLAGS_VALID_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sel_flag;
  logic is_add;
  logic [7:0] mem_byte;
  logic [8:0] add_sum;
  // branch selector picks flag bit 0, 1, 6 or 7
  assign sel_flag = FLAGS_OUT[{BRANCH_IN.sel[1], BRANCH_IN.sel[1], BRANCH_IN.sel[0]}];
  assign is_add = OP_VALID_IN && OP_REQ_IN.op == cfl_pkg::OP_ADD_CARRY && !FLAGS_OUT[3];
  assign mem_byte = OP_REQ_IN.mem;
  assign add_sum = {1'b0, OP_REQ_IN.acc} + {1'b0, mem_byte} + {8'h00, FLAGS_OUT[0]};
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // a soft trap request, then the stacked byte with the trap bit
  sequence s_trap_req;
    OP_VALID_IN && OP_REQ_IN.op == cfl_pkg::OP_SOFT_TRAP;
  endsequence
  sequence s_trap_done;
    STACKED_OUT == ($past(FLAGS_OUT) | 8'h10) && FLAGS_OUT[2];
  endsequence
  a_trap_bit_low: assert property (FLAGS_OUT[4] == 1'b0)
    else $error("trap bit set in live flags");
  a_trap_stack: assert property (s_trap_req |=> s_trap_done)
    else $error("soft trap stacked byte wrong");
  a_irq_mask_gate: assert property (IRQ_ACCEPT_OUT == (IRQ_PEND_IN && !FLAGS_OUT[2]))
    else $error("interrupt accept ignores mask");
  a_bcd_valid: assert property (FLAGS_VALID_OUT != BCD_MODE_OUT && BCD_MODE_OUT == FLAGS_OUT[3])
    else $error("decimal mode outputs wrong");
  a_pair_mode: assert property (PAIR_MODE_OUT == FLAGS_OUT[5])
    else $error("pair mode output wrong");
  a_branch_pick: assert property (BRANCH_TAKEN_OUT == (sel_flag == BRANCH_IN.want))
    else $error("branch decision wrong");
  a_bin_add_sum: assert property (is_add |=> {FLAGS_OUT[0], RESULT_OUT} == $past(add_sum))
    else $error("binary add sum or carry wrong");
  a_bit_test_copy: assert property (OP_VALID_IN && OP_REQ_IN.op == cfl_pkg::OP_BIT_TEST
    |=> FLAGS_OUT[7:6] == $past(mem_byte) >> 6)
    else $error("bit test flags wrong");
  a_move_flags: assert property (OP_VALID_IN && OP_REQ_IN.op == cfl_pkg::OP_TRANSFER
    |=> RESULT_OUT == $past(mem_byte) && FLAGS_OUT[1] == (RESULT_OUT == 8'h00)
    && FLAGS_OUT[7] == RESULT_OUT[7])
    else $error("transfer result flags wrong");
endmodule

/* File: verification/tb.sv */
// Purpose: self-checking bench for the core status flag block
// Assumes: strobes and ops driven just after rising edges, one cycle each
// Notes: one table walks arithmetic, shifts, moves, stacking and flag ops
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic op_valid = 1'b0;
  cfl_pkg::cfl_op_req_t op_req = '0;
  cfl_pkg::cfl_branch_t branch = '0;
  logic irq_pend = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] flags;
  logic [7:0] result;
  logic [7:0] stacked;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int i;
  // rows: op, acc, mem, result, flags, stacked byte
  localparam logic [47:0] STEPS [0:28] = '{
    48'h01_7F_01_80_C0_00, 48'h01_FF_01_00_03_00, 48'h02_00_01_FF_80_00,
    48'h02_80_01_7E_41_00, 48'h04_81_00_02_41_00, 48'h05_01_00_00_43_00,
    48'h06_80_00_01_41_00, 48'h07_00_00_80_C0_00, 48'h03_00_00_00_42_00,
    48'h03_00_90_90_C0_00, 48'h08_0F_40_90_42_00, 48'h12_00_00_90_42_42,
    48'h14_00_00_90_46_52, 48'h0C_00_00_90_42_52, 48'h15_00_00_90_46_42,
    48'h13_00_FF_90_EF_42, 48'h11_00_00_90_AF_42, 48'h0A_00_00_90_AE_42,
    48'h0C_00_00_90_AA_42, 48'h0E_00_00_90_A2_42, 48'h10_00_00_90_82_42,
    48'h09_00_00_90_83_42, 48'h0B_00_00_90_87_42, 48'h0F_00_00_90_A7_42,
    48'h0D_00_00_90_AF_42, 48'h01_09_00_10_2C_42, 48'h01_99_01_00_2D_42,
    48'h02_10_01_09_2D_42, 48'h04_09_00_12_2C_42};
  cfl_status_flags dut (
    .CORE_CLK_IN(clk), .RSTN_IN(rstn), .OP_VALID_IN(op_valid), .OP_REQ_IN(op_req),
    .BRANCH_IN(branch), .IRQ_PEND_IN(irq_pend), .REG_ADDR_IN(reg_addr),
    .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd),
    .REG_RDATA_OUT(rdata), .FLAGS_OUT(flags), .RESULT_OUT(result), .STACKED_OUT(stacked),
    .BRANCH_TAKEN_OUT(), .IRQ_ACCEPT_OUT(), .BCD_MODE_OUT(), .PAIR_MODE_OUT(),
    .FLAGS_VALID_OUT()
  );
  // 50 MHz core clock
  always #10 clk = ~clk;
  // compare one value and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle register write, visible after its edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // one-cycle register read, data checked in the following cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // issue one table row and check the outputs after its edge
  task automatic run_step(input int k);
    logic [47:0] s;
    s = STEPS[k];
    @(posedge clk);
    op_valid <= 1'b1;
    op_req <= {s[44:40], s[39:32], s[31:24]};
    branch <= cfl_pkg::cfl_branch_t'(k[2:0]);
    irq_pend <= k[0];
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    chk(result, s[23:16]);
    if (s[11]) chk(flags & 8'h3D, s[15:8] & 8'h3D);
    else chk(flags, s[15:8]);
    chk(stacked, s[7:0]);
  endtask
  // counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(flags, cfl_pkg::FLAG_RST);
    rd(4'h0, 8'h04);
    rd(4'h3, 8'h09);
    rd(4'hF, 8'h00);
    wr(4'h0, 8'hFF);
    chk(flags, 8'hEF);
    rd(4'h3, 8'h0E);
    wr(4'h1, 8'h55);
    rd(4'h1, 8'h00);
    wr(4'h0, 8'h00);
    $display("test registers done");
    for (i = 0; i < 29; i++) run_step(i);
    $display("test operations done");
    rd(4'h1, 8'h12);
    rd(4'h2, 8'h42);
    $display("test readback done");
    print_verdict();
  end
endmodule
bind cfl_status_flags cfl_flags_asserts u_chk (
  .CORE_CLK_IN, .RSTN_IN, .OP_VALID_IN, .OP_REQ_IN, .BRANCH_IN, .IRQ_PEND_IN, .FLAGS_OUT,
  .RESULT_OUT, .STACKED_OUT, .BRANCH_TAKEN_OUT, .IRQ_ACCEPT_OUT, .BCD_MODE_OUT,
  .PAIR_MODE_OUT, .FLAGS_VALID_OUT
);
